// *** logic/sdram_defs.svh ***
`ifndef SDRAM_DEFS_SVH
`define SDRAM_DEFS_SVH

// clock period and write recovery time, both in ns
`define CLK_NS       50
`define TWR_NS       15
// least time rounds up, never below one cycle
`define TWR_CYC      (((`TWR_NS + `CLK_NS - 1) / `CLK_NS) < 1 ? 1 : ((`TWR_NS + `CLK_NS - 1) / `CLK_NS))

// address bit that carries auto precharge or all-bank precharge
`define AP_BIT       10
// burst length code on burst_code
`define BL_FULL_CODE 3'h7

`endif

// *** logic/sdram_pkg.sv ***
package sdram_pkg;

   // {row strobe, column strobe, write enable}, all active low
   typedef enum logic [2:0] {
      CMD_ACTIVATE  = 3'h3,
      CMD_READ      = 3'h5,
      CMD_WRITE     = 3'h4,
      CMD_PRECHARGE = 3'h2,
      CMD_NOP       = 3'h7
   } cmd_t;

endpackage

// *** logic/sdram_core.sv ***
`include "sdram_defs.svh"

module sdram_wfifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input  wire logic             clock,     // system clock
   input  wire logic             rst,       // async reset
   input  wire logic             in_valid,  // element offered
   output      logic             in_ready,  // room for an element
   input  wire logic [WIDTH-1:0] in_data,   // element
   output      logic             out_valid, // element waiting
   input  wire logic             out_ready, // drain takes element
   output      logic [WIDTH-1:0] out_data,  // oldest element
   output      logic             full       // no room left
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wp_q;
   logic [AW-1:0]    rp_q;
   logic [AW:0]      cnt_q;
   logic             full_q;
   wire              push = in_valid & in_ready;
   wire              pop  = out_valid & out_ready;
   wire [AW:0]       cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);

   // count is one bit wider than the pointers so that full and empty differ
   assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
   assign full      = full_q;
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem[rp_q];

   always_ff @(posedge clock) begin
      if (push) begin
         mem[wp_q] <= in_data;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
         full_q <= 1'b0;
      end else begin
         if (push) wp_q <= (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
         if (pop) rp_q <= (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
         cnt_q  <= cnt_d;
         full_q <= (cnt_d == (AW+1)'(DEPTH));
      end
   end
endmodule

module sdram_core #(
   parameter int ROW_W  = 12,
   parameter int COL_W  = 8,
   parameter int DQ_W   = 16,
   parameter int FIFO_D = 8
) (
   input  wire logic              clock,      // system clock
   input  wire logic              rst,        // async reset
   input  wire logic              cs_n,       // chip select
   input  wire logic              ras_n,      // row strobe
   input  wire logic              cas_n,      // column strobe
   input  wire logic              we_n,       // write enable
   input  wire logic [1:0]        ba,         // bank select
   input  wire logic [11:0]       addr,       // row / column address
   input  wire logic [DQ_W-1:0]   dq_in,      // data pins in
   input  wire logic [1:0]        dqm,        // byte masks
   input  wire logic [1:0]        cas_lat,    // CAS latency, 2 or 3
   input  wire logic [2:0]        burst_code, // 0..3 = 1,2,4,8; 7 = full page
   output      logic [DQ_W-1:0]   dq_out,     // data pins out
   output      logic              dq_oe,      // data pins driven
   output      logic [3:0]        bank_open,  // row open per bank
   output      logic              wr_full     // write buffer full
);
   localparam int AW = 2 + ROW_W + COL_W;
   localparam int EW = AW + 2 + DQ_W;
   localparam logic [1:0] TWR = 2'(`TWR_CYC);

   logic [DQ_W-1:0]  mem [2**AW];
   logic [3:0]       open_q;
   logic [ROW_W-1:0] row_q [4];
   logic [3:0]       ap_pend_q;
   logic [1:0]       ap_cnt_q [4];
   logic             w_act_q, w_ap_q, w_full_q;
   logic [1:0]       w_bank_q;
   logic [COL_W-1:0] w_col_q;
   logic [8:0]       w_left_q;
   logic             r_act_q, r_ap_q, r_full_q;
   logic [1:0]       r_bank_q;
   logic [COL_W-1:0] r_col_q;
   logic [8:0]       r_left_q;
   logic [DQ_W-1:0]  rdat_q, p1_q;
   logic             rv_q, p1v_q;
   logic [DQ_W-1:0]  dq_out_q;
   logic             dq_oe_q;

   // chip select high turns any command into a NOP
   wire sdram_pkg::cmd_t cmd = cs_n ? sdram_pkg::CMD_NOP : sdram_pkg::cmd_t'({ras_n, cas_n, we_n});
   wire act_cmd = (cmd == sdram_pkg::CMD_ACTIVATE);
   wire pre_cmd = (cmd == sdram_pkg::CMD_PRECHARGE);
   // access to a bank that the controller left idle is dropped
   wire wr_cmd  = (cmd == sdram_pkg::CMD_WRITE) & open_q[ba];
   wire rd_cmd  = (cmd == sdram_pkg::CMD_READ) & open_q[ba];
   wire ap_flag = addr[`AP_BIT];
   wire full_pg = (burst_code == `BL_FULL_CODE);
   wire [8:0] bl = full_pg ? 9'h100 : 9'(9'h1 << burst_code[1:0]);

   // a new access of either kind ends the running write at this edge
   wire w_cut  = w_act_q & (wr_cmd | rd_cmd);
   wire w_last = w_act_q & ~w_cut & ~w_full_q & (w_left_q == 9'h1);
   wire w_end  = w_cut | w_last;
   // data on the read edge is ignored; last element was one clock before
   wire w_elem = wr_cmd | (w_act_q & ~rd_cmd & ~wr_cmd);
   wire [1:0]       e_bank = wr_cmd ? ba : w_bank_q;
   wire [COL_W-1:0] e_col  = wr_cmd ? addr[COL_W-1:0] : w_col_q;
   wire [EW-1:0]    e_data = {e_bank, row_q[e_bank], e_col, dqm, dq_in};

   wire r_cut  = r_act_q & (wr_cmd | rd_cmd);
   wire r_last = r_act_q & ~r_cut & ~r_full_q & (r_left_q == 9'h1);
   wire r_elem = rd_cmd | (r_act_q & ~wr_cmd);
   wire [1:0]       rd_bank = rd_cmd ? ba : r_bank_q;
   wire [COL_W-1:0] rd_col  = rd_cmd ? addr[COL_W-1:0] : r_col_q;
   wire [AW-1:0]    rd_addr = {rd_bank, row_q[rd_bank], rd_col};
   wire             r_ap_done = (r_cut | r_last) & r_ap_q;
   // a single access with auto precharge ends on its own command edge
   wire             one_ap    = (wr_cmd | rd_cmd) & ap_flag & ~full_pg & (bl == 9'h1);

   // the array has one port; reads win and the drain waits
   wire             f_valid;
   wire [EW-1:0]    f_data;
   wire             f_take = f_valid & ~r_elem;
   wire [AW-1:0]    f_addr = f_data[EW-1 -: AW];
   wire [1:0]       f_mask = f_data[DQ_W +: 2];

   sdram_wfifo #(.WIDTH(EW), .DEPTH(FIFO_D)) u_wfifo (
      .clock     (clock),
      .rst       (rst),
      .in_valid  (w_elem & (dqm != 2'h3)),
      .in_ready  (),
      .in_data   (e_data),
      .out_valid (f_valid),
      .out_ready (f_take),
      .out_data  (f_data),
      .full      (wr_full)
   );

   always_ff @(posedge clock) begin
      if (f_take) begin
         if (!f_mask[0]) mem[f_addr][7:0] <= f_data[7:0];
         if (!f_mask[1]) mem[f_addr][DQ_W-1:8] <= f_data[DQ_W-1:8];
      end
      rdat_q <= mem[rd_addr];
      p1_q   <= rdat_q;
   end

   // bank state: activate, precharge, and deferred auto precharge
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         open_q    <= '0;
         ap_pend_q <= '0;
         for (int b = 0; b < 4; b++) begin
            row_q[b]    <= '0;
            ap_cnt_q[b] <= '0;
         end
      end else begin
         for (int b = 0; b < 4; b++) begin
            if (ap_pend_q[b] && ap_cnt_q[b] == 2'h0) begin
               open_q[b]    <= 1'b0;
               ap_pend_q[b] <= 1'b0;
            end else if (ap_pend_q[b]) begin
               ap_cnt_q[b] <= ap_cnt_q[b] - 2'h1;
            end
            if (w_end && w_ap_q && w_bank_q == 2'(b)) begin
               // recovery counts from the interrupting or last-data edge
               ap_pend_q[b] <= 1'b1;
               ap_cnt_q[b]  <= TWR - 2'h1;
            end
            if (r_ap_done && r_bank_q == 2'(b)) open_q[b] <= 1'b0;
            if (one_ap && wr_cmd && ba == 2'(b)) begin
               ap_pend_q[b] <= 1'b1;
               ap_cnt_q[b]  <= TWR - 2'h1;
            end
            if (one_ap && rd_cmd && ba == 2'(b)) open_q[b] <= 1'b0;
            if (pre_cmd && (ap_flag || ba == 2'(b))) open_q[b] <= 1'b0;
            if (act_cmd && ba == 2'(b)) begin
               open_q[b] <= 1'b1;
               row_q[b]  <= addr[ROW_W-1:0];
            end
         end
      end
   end

   // write burst tracker; other banks stay usable meanwhile
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         w_act_q  <= 1'b0;
         w_ap_q   <= 1'b0;
         w_full_q <= 1'b0;
         w_bank_q <= '0;
         w_col_q  <= '0;
         w_left_q <= '0;
      end else if (wr_cmd) begin
         w_act_q  <= (bl != 9'h1);
         w_ap_q   <= ap_flag & ~full_pg;
         w_full_q <= full_pg;
         w_bank_q <= ba;
         w_col_q  <= addr[COL_W-1:0] + 1'b1;
         w_left_q <= bl - 9'h1;
      end else if (w_end) begin
         w_act_q <= 1'b0;
      end else if (w_act_q) begin
         w_col_q  <= w_col_q + 1'b1;
         w_left_q <= w_left_q - 9'h1;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         r_act_q  <= 1'b0;
         r_ap_q   <= 1'b0;
         r_full_q <= 1'b0;
         r_bank_q <= '0;
         r_col_q  <= '0;
         r_left_q <= '0;
      end else if (rd_cmd) begin
         r_act_q  <= (bl != 9'h1);
         r_ap_q   <= ap_flag & ~full_pg;
         r_full_q <= full_pg;
         r_bank_q <= ba;
         r_col_q  <= addr[COL_W-1:0] + 1'b1;
         r_left_q <= bl - 9'h1;
      end else if (r_cut || r_last) begin
         r_act_q <= 1'b0;
      end else if (r_act_q) begin
         r_col_q  <= r_col_q + 1'b1;
         r_left_q <= r_left_q - 9'h1;
      end
   end

   // read data leaves CAS latency after the read edge
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rv_q     <= 1'b0;
         p1v_q    <= 1'b0;
         dq_oe_q  <= 1'b0;
         dq_out_q <= '0;
      end else begin
         rv_q  <= r_elem;
         p1v_q <= rv_q;
         if (cas_lat == 2'h3) begin
            dq_oe_q  <= p1v_q;
            dq_out_q <= p1_q;
         end else begin
            dq_oe_q  <= rv_q;
            dq_out_q <= rdat_q;
         end
      end
   end

   assign dq_out    = dq_out_q;
   assign dq_oe     = dq_oe_q;
   assign bank_open = open_q;
endmodule

// *** test/sdram_core_props.sv ***
module sdram_core_props (
   input wire logic        clock,      // clock
   input wire logic        rst,        // reset
   input wire logic        cs_n,       // select
   input wire logic        ras_n,      // row
   input wire logic        cas_n,      // column
   input wire logic        we_n,       // write
   input wire logic [1:0]  ba,         // bank
   input wire logic [11:0] addr,       // address
   input wire logic [1:0]  cas_lat,    // latency
   input wire logic [2:0]  burst_code, // burst
   input wire logic        dq_oe,      // read drive
   input wire logic [3:0]  bank_open   // open rows
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] cmd;
   logic       rd;
   logic       wap0;
   assign cmd = {ras_n, cas_n, we_n};
   assign rd = !cs_n && cmd == sdram_pkg::CMD_READ && bank_open[ba];
   assign wap0 = !cs_n && cmd == sdram_pkg::CMD_WRITE && ba == 2'h0 && addr[10] && bank_open[0];
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   property p_act; !cs_n && cmd == sdram_pkg::CMD_ACTIVATE |=> bank_open[$past(ba)]; endproperty
   a_act: assert property (p_act) else $error("row not open after activate");
   property p_cs_act; cs_n |=> (bank_open & ~$past(bank_open)) == 4'h0; endproperty
   a_cs_act: assert property (p_cs_act) else $error("row opened while deselected");
   property p_cs_rd; cs_n && $past(cs_n) && $past(cs_n, 2) && !dq_oe |-> ##2 !dq_oe; endproperty
   a_cs_rd: assert property (p_cs_rd) else $error("read data while deselected");
   property p_cl2; rd && cas_lat == 2'h2 |-> ##2 dq_oe; endproperty
   a_cl2: assert property (p_cl2) else $error("read data late at latency 2");
   property p_cl3; rd && cas_lat == 2'h3 |-> ##3 dq_oe; endproperty
   a_cl3: assert property (p_cl3) else $error("read data late at latency 3");
   property p_ap4; wap0 && burst_code == 3'h2 ##1 cs_n [*3] |=> bank_open[0] ##1 !bank_open[0]; endproperty
   a_ap4: assert property (p_ap4) else $error("auto precharge timing after burst");
   property p_cut;
      wap0 && burst_code == 3'h3 ##2 !cs_n && cmd[2:1] == 2'h2 && ba == 2'h1 && bank_open[1]
         |=> bank_open[0] ##1 !bank_open[0];
   endproperty
   a_cut: assert property (p_cut) else $error("precharge timing after cut");
   property p_pre; !cs_n && cmd == sdram_pkg::CMD_PRECHARGE && addr[10] |=> bank_open == 4'h0; endproperty
   a_pre: assert property (p_pre) else $error("rows open after precharge all");
   property p_ap1;
      !cs_n && cmd == sdram_pkg::CMD_WRITE && addr[10] && bank_open[ba] && burst_code == 3'h0
         |-> ##2 !bank_open[$past(ba, 2)];
   endproperty
   a_ap1: assert property (p_ap1) else $error("single write kept row open");
endmodule

bind sdram_core sdram_core_props props_u (.clock, .rst, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr,
   .cas_lat, .burst_code, .dq_oe, .bank_open);

// *** test/sdram_ctrl_model.sv ***
module sdram_ctrl_model (
   input  wire logic        clock, // clock
   output      logic        cs_n,  // select
   output      logic        ras_n, // row
   output      logic        cas_n, // column
   output      logic        we_n,  // write
   output      logic [1:0]  ba,    // bank
   output      logic [11:0] addr,  // address
   output      logic [15:0] dq_in, // data
   output      logic [1:0]  dqm    // mask
);
   timeunit 1ns;
   timeprecision 1ns;
   logic       cs_off = 1'b0;
   logic [1:0] mask   = 2'h0;
   initial begin
      {cs_n, ras_n, cas_n, we_n} = 4'hF;
      ba = 2'h0;
      addr = 12'h000;
      dq_in = 16'h0000;
      dqm = 2'h0;
   end
   // callers open a row before any access and wait out precharge
   // no mode load or refresh is sent: latency and burst are plain inputs
   task automatic cmd(input sdram_pkg::cmd_t c, input logic [1:0] b, input logic [11:0] a, input logic [15:0] d);
      @(posedge clock);
      cs_n <= cs_off;
      {ras_n, cas_n, we_n} <= c;
      ba <= b;
      addr <= a;
      dq_in <= d;
      dqm <= mask;
   endtask
   task automatic dat(input logic [15:0] d);
      @(posedge clock);
      cs_n <= 1'b1;
      {ras_n, cas_n, we_n} <= sdram_pkg::CMD_NOP;
      dq_in <= d;
      dqm <= mask;
   endtask
   // idle data lines flip so a stale word never looks valid
   task automatic idle(input int n);
      repeat (n) dat(~dq_in);
   endtask
endmodule

// *** test/sdram_core_bench.sv ***
module sdram_core_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clock = 1'b0;
   logic        rst = 1'b1;
   logic [1:0]  cas_lat = 2'h2;
   logic [2:0]  burst_code = 3'h2;
   logic        cs_n, ras_n, cas_n, we_n, dq_oe, wr_full;
   logic [1:0]  ba, dqm;
   logic [11:0] addr;
   logic [15:0] dq_in, dq_out;
   logic [3:0]  bank_open;
   int          fail_count = 0;
   int          num_checks = 0;
   int          cycles = 0;
   always #25 clock = ~clock;
   sdram_ctrl_model ctl_u (.clock, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr, .dq_in, .dqm);
   sdram_core #(.ROW_W(2)) dut_u (.clock, .rst, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr, .dq_in, .dqm,
      .cas_lat, .burst_code, .dq_out, .dq_oe, .bank_open, .wr_full);
   task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic cfg(input logic [1:0] cl, input logic [2:0] bc);
      @(posedge clock);
      cas_lat <= cl;
      burst_code <= bc;
   endtask
   task automatic act(input logic [1:0] b);
      ctl_u.cmd(sdram_pkg::CMD_ACTIVATE, b, 12'h000, 16'h0000);
   endtask
   // every write carries auto precharge
   task automatic wr(input logic [1:0] b, input logic [7:0] c, input logic [15:0] d, input int n);
      ctl_u.cmd(sdram_pkg::CMD_WRITE, b, {4'h4, c}, d);
      for (int i = 1; i < n; i++)
         ctl_u.dat(d + 16'(i));
   endtask
   task automatic rd(input logic [1:0] b, input logic [7:0] c, input logic [15:0] exp, input string what);
      ctl_u.cmd(sdram_pkg::CMD_READ, b, {4'h0, c}, 16'h0000);
      ctl_u.idle(1);
      repeat (cas_lat - 2'h1) @(posedge clock);
      @(negedge clock);
      check("read drive", {15'h0000, dq_oe}, 16'h0001);
      check(what, dq_out, exp);
      ctl_u.idle(8);
   endtask
   task automatic open_is(input logic [3:0] exp);
      @(negedge clock);
      check("open rows", {12'h000, bank_open}, {12'h000, exp});
   endtask
   task automatic t_ap_bl4();
      cfg(2'h2, 3'h2);
      act(2'h0);
      wr(2'h0, 8'h10, 16'hA000, 4);
      ctl_u.idle(4);
      open_is(4'h0);
      act(2'h0);
      rd(2'h0, 8'h13, 16'hA003, "burst tail");
      $display("t_ap_bl4 done");
   endtask
   task automatic t_wr_cut_wr();
      cfg(2'h2, 3'h3);
      act(2'h1);
      wr(2'h0, 8'h11, 16'hD000, 2);
      wr(2'h1, 8'h30, 16'hE000, 8);
      ctl_u.idle(4);
      open_is(4'h0);
      act(2'h0);
      rd(2'h0, 8'h12, 16'hD001, "last kept");
      rd(2'h0, 8'h13, 16'hA003, "cut word");
      $display("t_wr_cut_wr done");
   endtask
   task automatic t_wr_cut_rd();
      cfg(2'h3, 3'h3);
      act(2'h1);
      wr(2'h0, 8'h0E, 16'hB000, 2);
      rd(2'h1, 8'h30, 16'hE000, "cut read");
      open_is(4'h2);
      act(2'h0);
      rd(2'h0, 8'h0F, 16'hB001, "last kept");
      rd(2'h0, 8'h10, 16'hA000, "cut word");
      $display("t_wr_cut_rd done");
   endtask
   task automatic t_cs_nop();
      cfg(2'h2, 3'h0);
      ctl_u.cs_off = 1'b1;
      act(2'h2);
      wr(2'h0, 8'h10, 16'hBEEF, 1);
      ctl_u.cmd(sdram_pkg::CMD_READ, 2'h0, 12'h010, 16'h0000);
      ctl_u.cs_off = 1'b0;
      ctl_u.idle(2);
      open_is(4'h3);
      rd(2'h0, 8'h10, 16'hA000, "masked write");
      ctl_u.cmd(sdram_pkg::CMD_PRECHARGE, 2'h0, 12'h400, 16'h0000);
      ctl_u.idle(1);
      open_is(4'h0);
      $display("t_cs_nop done");
   endtask
   // reset with a row open, a plain then a byte-masked single write, then a full page cut by a read
   task automatic t_mask();
      cfg(2'h2, 3'h0);
      act(2'h1);
      ctl_u.idle(1);
      @(posedge clock);
      rst <= 1'b1;
      @(posedge clock);
      rst <= 1'b0;
      open_is(4'h0);
      check("read drive idle", {15'h0000, dq_oe}, 16'h0000);
      check("read data idle", dq_out, 16'h0000);
      check("write buffer full", {15'h0000, wr_full}, 16'h0000);
      act(2'h3);
      wr(2'h3, 8'h20, 16'h1234, 1);
      ctl_u.idle(2);
      open_is(4'h0);
      act(2'h3);
      ctl_u.mask = 2'h2;
      wr(2'h3, 8'h20, 16'h5678, 1);
      ctl_u.mask = 2'h0;
      ctl_u.idle(2);
      act(2'h3);
      rd(2'h3, 8'h20, 16'h1278, "byte mask");
      cfg(2'h2, 3'h7);
      wr(2'h3, 8'h40, 16'hC000, 3);
      rd(2'h3, 8'h41, 16'hC001, "full page cut");
      open_is(4'h8);
      $display("t_mask done");
   endtask
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         fail_count++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (4) @(posedge clock);
      rst <= 1'b0;
      t_ap_bl4();
      t_wr_cut_wr();
      t_wr_cut_rd();
      t_cs_nop();
      t_mask();
      tally_and_finish();
   end
endmodule
